// ==== design/epcd_regs.svh ====
`ifndef EPCD_REGS_SVH
`define EPCD_REGS_SVH
// Command codes
`define EPCD_CMD_SENSOR_WR 8'h1c
`define EPCD_CMD_ACTIVATE  8'h20
`define EPCD_CMD_RAM_OPT   8'h21
`define EPCD_CMD_SEQ_OPT   8'h22
`define EPCD_CMD_WR_MONO   8'h24
`define EPCD_CMD_WR_COLOR  8'h26
`define EPCD_CMD_RD_RAM    8'h27
`define EPCD_CMD_SENSE     8'h28
`define EPCD_CMD_SENSE_DUR 8'h29
`define EPCD_CMD_PROG_COMMON_ELECTRODE_LEVEL 8'h2a
`define EPCD_CMD_CRC       8'h34
`define EPCD_CMD_CRC_RD    8'h35
`define EPCD_CMD_PROG_SEL  8'h36
`define EPCD_CMD_DISP_OPT  8'h37
`define EPCD_CMD_USER_ID   8'h38
`define EPCD_CMD_RD_OPT    8'h41
// Reset values
`define EPCD_RST_SEQ_OPT   8'hff
`define EPCD_RST_RAM_OPT   8'h00
`define EPCD_RST_SENSOR    8'h00
`define EPCD_RST_SENSE_DUR 8'h49
`define EPCD_RST_CRC       16'hffff
// Field positions
`define EPCD_SEQ_CLK_ON    7
`define EPCD_SEQ_ANA_ON    6
`define EPCD_SEQ_TEMP      5
`define EPCD_SEQ_LUT       4
`define EPCD_SEQ_MODE2     3
`define EPCD_SEQ_DISP      2
`define EPCD_SEQ_ANA_OFF   1
`define EPCD_SEQ_CLK_OFF   0
`define EPCD_OPT_ALT_BYTE  5
// Counts and timing
`define EPCD_OPT_BYTES     4'ha
`define EPCD_OTP_BYTES     5'h15
`define EPCD_OTP_COMMON_ELECTRODE_LEVEL_IDX  5'h14
`define EPCD_MCLK_HZ       100000000
`define EPCD_SENSE_UNIT_S  1
`define EPCD_SENSE_CYCLES  (`EPCD_SENSE_UNIT_S * `EPCD_MCLK_HZ)
`define EPCD_OP_CYCLES     32'h0000_0040
`endif

// ==== design/epcd_pkg.sv ====
package epcd_pkg;
   typedef enum logic [2:0] {
      ST_IDLE   = 3'b000,
      ST_SENSOR = 3'b001,
      ST_SEQ    = 3'b010,
      ST_SENSE  = 3'b011,
      ST_PROG   = 3'b100,
      ST_CRC    = 3'b101
   } epcd_state_type;
endpackage

// ==== design/epcd_link_if.sv ====
`timescale 1ns/1ps
`default_nettype none
interface epcd_link_if;
   logic       rx_valid;
   logic       rx_is_data;
   logic [7:0] rx_byte;
   logic [7:0] tx_byte;
   logic       read_mode;
   modport shifter (output rx_valid, rx_is_data, rx_byte, input tx_byte, read_mode);
   modport decoder (input rx_valid, rx_is_data, rx_byte, output tx_byte, read_mode);
endinterface
`default_nettype wire

// ==== design/epcd_spi_shifter.sv ====
`timescale 1ns/1ps
`default_nettype none
module epcd_spi_shifter (
   input  wire logic       mclk,
   input  wire logic       rst,
   input  wire logic       scl,
   input  wire logic       sdi,
   input  wire logic       cs_n,
   input  wire logic       dc,
   input  wire logic       bs1,
   epcd_link_if.shifter    lnk,
   output logic            sdo,
   output logic            sdo_oe
);
   // Pin order: bs1, dc, cs_n, sdi, scl
   logic [4:0] s1_ff, s2_ff;
   logic       scl_d_ff, nxt_scl_d;
   logic [3:0] cnt_ff, nxt_cnt;
   logic [8:0] sh_ff, nxt_sh;
   logic [7:0] txsh_ff, nxt_txsh;
   logic       sdo_ff, nxt_sdo, oe_ff, nxt_oe;
   logic       val_ff, nxt_val, isd_ff, nxt_isd;
   logic [7:0] byte_ff, nxt_byte;
   logic       rise, fall, three;
   logic [3:0] last, hdr;

   always_comb begin
      rise      = s2_ff[0] & ~scl_d_ff;
      fall      = ~s2_ff[0] & scl_d_ff;
      three     = s2_ff[4];
      last      = three ? 4'h8 : 4'h7;
      hdr       = three ? 4'h1 : 4'h0;
      nxt_scl_d = s2_ff[0];
      nxt_cnt   = cnt_ff;
      nxt_sh    = sh_ff;
      nxt_txsh  = txsh_ff;
      nxt_sdo   = sdo_ff;
      nxt_val   = 1'b0;
      nxt_isd   = isd_ff;
      nxt_byte  = byte_ff;
      nxt_oe    = ~s2_ff[2] & lnk.read_mode;
      if (s2_ff[2]) begin
         nxt_cnt = 4'h0;
      end else begin
         if (rise) begin
            nxt_sh = {sh_ff[7:0], s2_ff[1]}; // [R23] [R25]
            if (cnt_ff == last) begin
               nxt_cnt  = 4'h0;
               nxt_val  = 1'b1;
               nxt_byte = nxt_sh[7:0];
               nxt_isd  = three ? sh_ff[7] : s2_ff[3]; // [R23] [R25]
            end else begin
               nxt_cnt = cnt_ff + 4'h1;
            end
         end
         if (fall && cnt_ff == hdr) begin
            nxt_sdo  = lnk.tx_byte[7]; // [R24]
            nxt_txsh = {lnk.tx_byte[6:0], 1'b0};
         end else if (fall) begin
            nxt_sdo  = txsh_ff[7];
            nxt_txsh = {txsh_ff[6:0], 1'b0};
         end
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         s1_ff    <= 5'h04;
         s2_ff    <= 5'h04;
         scl_d_ff <= 1'b0;
         cnt_ff   <= 4'h0;
         sh_ff    <= 9'h000;
         txsh_ff  <= 8'h00;
         sdo_ff   <= 1'b0;
         oe_ff    <= 1'b0;
         val_ff   <= 1'b0;
         isd_ff   <= 1'b0;
         byte_ff  <= 8'h00;
      end else begin
         s1_ff    <= {bs1, dc, cs_n, sdi, scl};
         s2_ff    <= s1_ff;
         scl_d_ff <= nxt_scl_d;
         cnt_ff   <= nxt_cnt;
         sh_ff    <= nxt_sh;
         txsh_ff  <= nxt_txsh;
         sdo_ff   <= nxt_sdo;
         oe_ff    <= nxt_oe;
         val_ff   <= nxt_val;
         isd_ff   <= nxt_isd;
         byte_ff  <= nxt_byte;
      end
   end

   assign lnk.rx_valid   = val_ff;
   assign lnk.rx_is_data = isd_ff;
   assign lnk.rx_byte    = byte_ff;
   assign sdo            = sdo_ff;
   assign sdo_oe         = oe_ff;

   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);
   property p_rx_pulse;
      val_ff |=> !val_ff;
   endproperty
   a_rx_pulse: assert property (p_rx_pulse) else $error("byte strobe longer than one cycle"); // [R23]
   property p_oe_off;
      s2_ff[2] |=> !oe_ff;
   endproperty
   a_oe_off: assert property (p_oe_off) else $error("output driven while deselected"); // [R24]
endmodule // epcd_spi_shifter
`default_nettype wire

// ==== design/epcd_cmd_decoder.sv ====
//Contract
// R1 - Sensor write: three bytes, count and pointer
// R2 - Sensor write needs clock; busy during transfer
// R3 - Activation runs stored sequence under busy
// R4 - Host must not interrupt an update
// R5 - RAM option nibbles: normal, zero, invert
// R6 - Sequence option byte, reset all ones
// R7 - Codes 80, C0, 03 steer power flags
// R8 - Codes 91, 99 load table, clock off
// R9 - Codes 47, 4F display, then power down
// R10 - Mono writes store bytes, address advances
// R11 - Color writes store bytes, address advances
// R12 - Memory read: dummy first, chosen plane
// R13 - Sense needs clock and analog; busy
// R14 - Sense time is nibble plus one seconds
// R15 - Program electrode level needs clock; busy
// R16 - CRC over programmable memory under busy
// R17 - CRC read returns two bytes, MSB first
// R18 - Program options and user ID needs clock
// R19 - Option bytes: mode map, alternating buffers
// R20 - Option tail holds identifiers; all storable
// R21 - User ID takes ten bytes
// R22 - Read option bit zero selects plane
// R23 - Four-wire: rising edge, MSB first, select
// R24 - Reads shift out on falling edges
// R25 - Three-wire: nine bits, select bit first
// R26 - Excess parameter bytes ignored; command resets count
`timescale 1ns/1ps
`default_nettype none
`include "epcd_regs.svh"
module epcd_cmd_decoder #(
   parameter logic [31:0] SEC_CYCLES = `EPCD_SENSE_CYCLES
) (
   input  wire logic       mclk,
   input  wire logic       rst,
   input  wire logic       scl,
   input  wire logic       sdi,
   input  wire logic       cs_n,
   input  wire logic       dc,
   input  wire logic       bs1,
   input  wire logic [7:0] sensed_level,
   output logic            sdo,
   output logic            sdo_oe,
   output logic            busy,
   output logic            clock_enable_flag,
   output logic            analog_enable_flag,
   output logic            sensor_start,
   output logic [7:0]      sensor_cfg,
   output logic [7:0]      sensor_param1,
   output logic [7:0]      sensor_param2,
   output logic [7:0]      ram_option,
   output logic            stage_temp_load,
   output logic            stage_lut_load,
   output logic            stage_display,
   output logic            display_mode2,
   output logic [1:0]      alternating_buffer_flag,
   output logic [7:0]      common_electrode_level
);
   epcd_link_if lnk ();
   epcd_spi_shifter u_shift (
      .mclk   (mclk),
      .rst    (rst),
      .scl    (scl),
      .sdi    (sdi),
      .cs_n   (cs_n),
      .dc     (dc),
      .bs1    (bs1),
      .lnk    (lnk),
      .sdo    (sdo),
      .sdo_oe (sdo_oe)
   );

   // ----------------------------------------------------------------
   // Storage
   // ----------------------------------------------------------------
   logic [7:0] mono_plane_memory [256];
   logic [7:0] color_plane_memory [256];
   logic [7:0] opt_mem [10];
   logic [7:0] uid_mem [10];
   logic [7:0] otp_mem [21];

   epcd_pkg::epcd_state_type st_ff, nxt_st;
   logic [7:0]  cmd_ff, nxt_cmd, addr_ff, nxt_addr, tx_ff, nxt_tx;
   logic [3:0]  pidx_ff, nxt_pidx;
   logic [31:0] cnt_ff, nxt_cnt;
   logic        busy_ff, nxt_busy, clk_ff, nxt_clk, ana_ff, nxt_ana;
   logic [7:0]  seq_ff, nxt_seq, ropt_ff, nxt_ropt, dur_ff, nxt_dur;
   logic [7:0]  sa_ff, nxt_sa, sb_ff, nxt_sb, sc_ff, nxt_sc, common_electrode_level_ff, nxt_common_electrode_level;
   logic        rsel_ff, nxt_rsel, rmode_ff, nxt_rmode;
   logic [15:0] crc_ff, nxt_crc;
   logic [4:0]  cidx_ff, nxt_cidx;
   logic        sstart_ff, nxt_sstart, temp_ff, nxt_temp, lut_ff, nxt_lut;
   logic        disp_ff, nxt_disp, mode2_ff, nxt_mode2;
   logic [1:0]  alt_ff, nxt_alt;
   logic        we_mono, we_color, we_opt, we_uid, prog_sel, prog_common_electrode_level;
   logic        cmd_ev, dat_ev;
   logic [1:0]  need;

   // CRC-16, polynomial 1021h, one byte per clock
   function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] d);
      logic [15:0] r;
      r = c ^ {d, 8'h00};
      for (int i = 0; i < 8; i++) begin
         r = r[15] ? ((r << 1) ^ 16'h1021) : (r << 1);
      end
      return r;
   endfunction

   // RAM option nibble: 0100 forces zero, 1000 inverts
   function automatic logic [7:0] plane_view(input logic [7:0] d, input logic [3:0] o);
      return o[2] ? 8'h00 : (o[3] ? ~d : d);
   endfunction

   // ----------------------------------------------------------------
   // Command decode and sequencing
   // ----------------------------------------------------------------
   always_comb begin
      cmd_ev     = lnk.rx_valid & ~lnk.rx_is_data;
      dat_ev     = lnk.rx_valid & lnk.rx_is_data;
      need       = (sa_ff[7:6] == 2'b00) ? 2'h3 : ((sa_ff[7:6] == 2'b01) ? 2'h2 : 2'h1);
      nxt_st     = st_ff;
      nxt_cmd    = cmd_ff;
      nxt_addr   = addr_ff;
      nxt_tx     = tx_ff;
      nxt_pidx   = pidx_ff;
      nxt_cnt    = cnt_ff;
      nxt_busy   = busy_ff;
      nxt_clk    = clk_ff;
      nxt_ana    = ana_ff;
      nxt_seq    = seq_ff;
      nxt_ropt   = ropt_ff;
      nxt_dur    = dur_ff;
      nxt_sa     = sa_ff;
      nxt_sb     = sb_ff;
      nxt_sc     = sc_ff;
      nxt_common_electrode_level   = common_electrode_level_ff;
      nxt_rsel   = rsel_ff;
      nxt_rmode  = rmode_ff;
      nxt_crc    = crc_ff;
      nxt_cidx   = cidx_ff;
      nxt_alt    = alt_ff;
      nxt_sstart = 1'b0;
      nxt_temp   = 1'b0;
      nxt_lut    = 1'b0;
      nxt_disp   = 1'b0;
      nxt_mode2  = mode2_ff;
      we_mono    = 1'b0;
      we_color   = 1'b0;
      we_opt     = 1'b0;
      we_uid     = 1'b0;
      prog_sel   = 1'b0;
      prog_common_electrode_level  = 1'b0;
      if (cmd_ev) begin
         nxt_cmd   = lnk.rx_byte;
         nxt_pidx  = 4'h0; // [R26]
         nxt_rmode = 1'b0;
         case (lnk.rx_byte)
            `EPCD_CMD_ACTIVATE: if (st_ff == epcd_pkg::ST_IDLE) begin
               nxt_st    = epcd_pkg::ST_SEQ; // [R3]
               nxt_busy  = 1'b1;
               nxt_cnt   = `EPCD_OP_CYCLES;
               nxt_clk   = clk_ff | seq_ff[`EPCD_SEQ_CLK_ON]; // [R6] [R7]
               nxt_ana   = ana_ff | seq_ff[`EPCD_SEQ_ANA_ON]; // [R7] [R9]
               nxt_temp  = seq_ff[`EPCD_SEQ_TEMP];
               nxt_lut   = seq_ff[`EPCD_SEQ_LUT]; // [R8]
               nxt_disp  = seq_ff[`EPCD_SEQ_DISP]; // [R9]
               nxt_mode2 = seq_ff[`EPCD_SEQ_MODE2];
            end
            `EPCD_CMD_SENSE: if (st_ff == epcd_pkg::ST_IDLE && clk_ff && ana_ff) begin
               nxt_st   = epcd_pkg::ST_SENSE; // [R13]
               nxt_busy = 1'b1;
               nxt_cnt  = 32'({1'b0, dur_ff[3:0]} + 5'h01) * SEC_CYCLES; // [R14]
            end
            `EPCD_CMD_PROG_COMMON_ELECTRODE_LEVEL, `EPCD_CMD_PROG_SEL:
               if (st_ff == epcd_pkg::ST_IDLE && clk_ff) begin
                  nxt_st    = epcd_pkg::ST_PROG; // [R15] [R18]
                  nxt_busy  = 1'b1;
                  nxt_cnt   = `EPCD_OP_CYCLES;
                  prog_common_electrode_level = (lnk.rx_byte == `EPCD_CMD_PROG_COMMON_ELECTRODE_LEVEL);
                  prog_sel  = (lnk.rx_byte == `EPCD_CMD_PROG_SEL); // [R20] [R21]
               end
            `EPCD_CMD_CRC: if (st_ff == epcd_pkg::ST_IDLE) begin
               nxt_st   = epcd_pkg::ST_CRC; // [R16]
               nxt_busy = 1'b1;
               nxt_crc  = `EPCD_RST_CRC;
               nxt_cidx = 5'h00;
            end
            `EPCD_CMD_WR_MONO, `EPCD_CMD_WR_COLOR: nxt_addr = 8'h00;
            `EPCD_CMD_RD_RAM: begin
               nxt_addr  = 8'h00;
               nxt_tx    = 8'h00; // [R12]
               nxt_rmode = 1'b1;
            end
            `EPCD_CMD_CRC_RD: begin
               nxt_tx    = crc_ff[15:8]; // [R17]
               nxt_rmode = 1'b1;
            end
            default: nxt_rmode = 1'b0;
         endcase
      end else if (dat_ev) begin
         if (pidx_ff != 4'hf) begin
            nxt_pidx = pidx_ff + 4'h1;
         end
         case (cmd_ff)
            `EPCD_CMD_SENSOR_WR: begin
               if (pidx_ff == 4'h0) nxt_sa = lnk.rx_byte; // [R1]
               if (pidx_ff == 4'h1) nxt_sb = lnk.rx_byte;
               if (pidx_ff == 4'h2) nxt_sc = lnk.rx_byte;
               if (pidx_ff < 4'h3 && pidx_ff + 4'h1 == {2'b00, (pidx_ff == 4'h0) ?
                   ((lnk.rx_byte[7:6] == 2'b00) ? 2'h3 : ((lnk.rx_byte[7:6] == 2'b01) ? 2'h2 : 2'h1)) : need}
                   && clk_ff && st_ff == epcd_pkg::ST_IDLE) begin
                  nxt_sstart = 1'b1; // [R2]
                  nxt_st     = epcd_pkg::ST_SENSOR;
                  nxt_busy   = 1'b1;
                  nxt_cnt    = `EPCD_OP_CYCLES;
               end
            end
            `EPCD_CMD_RAM_OPT:   if (pidx_ff == 4'h0) nxt_ropt = lnk.rx_byte; // [R5] [R26]
            `EPCD_CMD_SEQ_OPT:   if (pidx_ff == 4'h0) nxt_seq = lnk.rx_byte; // [R6] [R26]
            `EPCD_CMD_SENSE_DUR: if (pidx_ff == 4'h0) nxt_dur = lnk.rx_byte; // [R14]
            `EPCD_CMD_RD_OPT:    if (pidx_ff == 4'h0) nxt_rsel = lnk.rx_byte[0]; // [R22]
            `EPCD_CMD_DISP_OPT: if (pidx_ff < `EPCD_OPT_BYTES) begin
               we_opt = 1'b1; // [R19] [R20]
               if (pidx_ff == 4'(`EPCD_OPT_ALT_BYTE)) nxt_alt = lnk.rx_byte[7:6];
            end
            `EPCD_CMD_USER_ID: we_uid = (pidx_ff < `EPCD_OPT_BYTES); // [R21]
            `EPCD_CMD_WR_MONO: begin
               we_mono  = 1'b1; // [R10]
               nxt_addr = addr_ff + 8'h01;
            end
            `EPCD_CMD_WR_COLOR: begin
               we_color = 1'b1; // [R11]
               nxt_addr = addr_ff + 8'h01;
            end
            `EPCD_CMD_RD_RAM: begin
               nxt_tx   = rsel_ff ? plane_view(color_plane_memory[addr_ff], ropt_ff[7:4])
                                  : plane_view(mono_plane_memory[addr_ff], ropt_ff[3:0]); // [R12] [R5]
               nxt_addr = addr_ff + 8'h01;
            end
            `EPCD_CMD_CRC_RD: nxt_tx = (pidx_ff == 4'h0) ? crc_ff[7:0] : 8'h00; // [R17]
            default: nxt_tx = tx_ff;
         endcase
      end
      case (st_ff)
         epcd_pkg::ST_CRC: begin
            nxt_crc  = crc_step(crc_ff, otp_mem[cidx_ff]); // [R16]
            nxt_cidx = cidx_ff + 5'h01;
            if (cidx_ff == `EPCD_OTP_BYTES - 5'h01) begin
               nxt_st   = epcd_pkg::ST_IDLE;
               nxt_busy = 1'b0;
            end
         end
         epcd_pkg::ST_IDLE: nxt_busy = nxt_busy;
         default: begin
            nxt_cnt = cnt_ff - 32'h1;
            if (cnt_ff == 32'h1) begin
               nxt_st   = epcd_pkg::ST_IDLE;
               nxt_busy = 1'b0;
               if (st_ff == epcd_pkg::ST_SENSE) nxt_common_electrode_level = sensed_level; // [R13]
               if (st_ff == epcd_pkg::ST_SEQ) begin
                  if (seq_ff[`EPCD_SEQ_ANA_OFF]) nxt_ana = 1'b0; // [R7] [R9]
                  if (seq_ff[`EPCD_SEQ_CLK_OFF]) nxt_clk = 1'b0; // [R8]
               end
            end
         end
      endcase
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         st_ff     <= epcd_pkg::ST_IDLE;
         cmd_ff    <= 8'h00;
         addr_ff   <= 8'h00;
         tx_ff     <= 8'h00;
         pidx_ff   <= 4'h0;
         cnt_ff    <= 32'h0;
         busy_ff   <= 1'b0;
         clk_ff    <= 1'b0;
         ana_ff    <= 1'b0;
         seq_ff    <= `EPCD_RST_SEQ_OPT;
         ropt_ff   <= `EPCD_RST_RAM_OPT;
         dur_ff    <= `EPCD_RST_SENSE_DUR;
         sa_ff     <= `EPCD_RST_SENSOR;
         sb_ff     <= `EPCD_RST_SENSOR;
         sc_ff     <= `EPCD_RST_SENSOR;
         common_electrode_level_ff   <= 8'h00;
         rsel_ff   <= 1'b0;
         rmode_ff  <= 1'b0;
         crc_ff    <= `EPCD_RST_CRC;
         cidx_ff   <= 5'h00;
         sstart_ff <= 1'b0;
         temp_ff   <= 1'b0;
         lut_ff    <= 1'b0;
         disp_ff   <= 1'b0;
         mode2_ff  <= 1'b0;
         alt_ff    <= 2'b00;
      end else begin
         st_ff     <= nxt_st;
         cmd_ff    <= nxt_cmd;
         addr_ff   <= nxt_addr;
         tx_ff     <= nxt_tx;
         pidx_ff   <= nxt_pidx;
         cnt_ff    <= nxt_cnt;
         busy_ff   <= nxt_busy;
         clk_ff    <= nxt_clk;
         ana_ff    <= nxt_ana;
         seq_ff    <= nxt_seq;
         ropt_ff   <= nxt_ropt;
         dur_ff    <= nxt_dur;
         sa_ff     <= nxt_sa;
         sb_ff     <= nxt_sb;
         sc_ff     <= nxt_sc;
         common_electrode_level_ff   <= nxt_common_electrode_level;
         rsel_ff   <= nxt_rsel;
         rmode_ff  <= nxt_rmode;
         crc_ff    <= nxt_crc;
         cidx_ff   <= nxt_cidx;
         sstart_ff <= nxt_sstart;
         temp_ff   <= nxt_temp;
         lut_ff    <= nxt_lut;
         disp_ff   <= nxt_disp;
         mode2_ff  <= nxt_mode2;
         alt_ff    <= nxt_alt;
      end
   end

   // Image planes carry no reset; contents are undefined until written
   always_ff @(posedge mclk) begin
      if (we_mono) mono_plane_memory[addr_ff] <= lnk.rx_byte;
      if (we_color) color_plane_memory[addr_ff] <= lnk.rx_byte;
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         for (int i = 0; i < 10; i++) begin
            opt_mem[i] <= 8'h00;
            uid_mem[i] <= 8'h00;
         end
         for (int i = 0; i < 21; i++) otp_mem[i] <= 8'h00;
      end else begin
         if (we_opt) opt_mem[pidx_ff] <= lnk.rx_byte;
         if (we_uid) uid_mem[pidx_ff] <= lnk.rx_byte;
         if (prog_common_electrode_level) otp_mem[`EPCD_OTP_COMMON_ELECTRODE_LEVEL_IDX] <= common_electrode_level_ff; // [R15]
         if (prog_sel) begin
            for (int i = 0; i < 10; i++) begin
               otp_mem[i]      <= opt_mem[i]; // [R18]
               otp_mem[i + 10] <= uid_mem[i];
            end
         end
      end
   end

   assign lnk.tx_byte             = tx_ff;
   assign lnk.read_mode           = rmode_ff;
   assign busy                    = busy_ff;
   assign clock_enable_flag       = clk_ff;
   assign analog_enable_flag      = ana_ff;
   assign sensor_start            = sstart_ff;
   assign sensor_cfg              = sa_ff;
   assign sensor_param1           = sb_ff;
   assign sensor_param2           = sc_ff;
   assign ram_option              = ropt_ff;
   assign stage_temp_load         = temp_ff;
   assign stage_lut_load          = lut_ff;
   assign stage_display           = disp_ff;
   assign display_mode2           = mode2_ff;
   assign alternating_buffer_flag = alt_ff;
   assign common_electrode_level  = common_electrode_level_ff;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);
   sequence s_activate;
      cmd_ev && lnk.rx_byte == `EPCD_CMD_ACTIVATE && st_ff == epcd_pkg::ST_IDLE;
   endsequence
   property p_seq_busy;
      s_activate |=> busy_ff [*8];
   endproperty
   a_seq_busy: assert property (p_seq_busy) else $error("busy dropped during update"); // [R3]
   property p_sensor_clk;
      sstart_ff |-> clk_ff && busy_ff;
   endproperty
   a_sensor_clk: assert property (p_sensor_clk) else $error("sensor write without clock"); // [R2]
   property p_sense_pow;
      st_ff == epcd_pkg::ST_SENSE |-> clk_ff && ana_ff && busy_ff;
   endproperty
   a_sense_pow: assert property (p_sense_pow) else $error("sense without power"); // [R13]
   property p_prog_clk;
      st_ff == epcd_pkg::ST_PROG |-> clk_ff;
   endproperty
   a_prog_clk: assert property (p_prog_clk) else $error("programming without clock"); // [R15]
   property p_crc_done;
      cmd_ev && lnk.rx_byte == `EPCD_CMD_CRC && st_ff == epcd_pkg::ST_IDLE |=> busy_ff ##21 !busy_ff;
   endproperty
   a_crc_done: assert property (p_crc_done) else $error("crc run length wrong"); // [R16]
   property p_excess;
      dat_ev && cmd_ff == `EPCD_CMD_SEQ_OPT && pidx_ff != 4'h0 |=> $stable(seq_ff);
   endproperty
   a_excess: assert property (p_excess) else $error("extra parameter byte taken"); // [R26]
   property p_mono_adv;
      dat_ev && cmd_ff == `EPCD_CMD_WR_MONO |=> addr_ff == $past(addr_ff) + 8'h01;
   endproperty
   a_mono_adv: assert property (p_mono_adv) else $error("address did not advance"); // [R10]
endmodule // epcd_cmd_decoder
`default_nettype wire

// ==== tb/epcd_host_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module epcd_host_model (
   input  wire logic mclk,
   input  wire logic sdo,
   input  wire logic sdo_oe,
   output logic      scl,
   output logic      sdi,
   output logic      cs_n,
   output logic      dc
);
   // ----------------------------------------
   // Byte transfer, one frame per byte, four-wire or nine-bit three-wire
   // ----------------------------------------
   initial begin
      scl  = 1'b0;
      sdi  = 1'b0;
      cs_n = 1'b1;
      dc   = 1'b0;
   end
   // Serial clock stands low outside frames; data line is flipped so a stale bit cannot pass
   // Read pin shows the inverse while not enabled, so a missing enable cannot pass
   task automatic xfer(input logic t, input logic d, input logic [7:0] w, output logic [7:0] r);
      logic [8:0] f;
      int         i;
      f    = {d, w};
      cs_n = 1'b0;
      dc   = t ? 1'b0 : d;
      // Odd offset keeps every serial edge clear of the mclk rising edges
      #41;
      for (i = t ? 8 : 7; i >= 0; i--) begin
         sdi = f[i];
         #62.5;
         if (i < 8) r[i] = sdo_oe ? sdo : ~sdo;
         scl = 1'b1;
         #62.5;
         scl = 1'b0;
      end
      repeat (6) @(negedge mclk);
      cs_n = 1'b1;
      sdi  = ~sdi;
      repeat (26) @(negedge mclk);
   endtask
endmodule // epcd_host_model
`default_nettype wire

// ==== tb/test_epaper_cmd_decoder_1c_38.sv ====
`timescale 1ns/1ps
`default_nettype none
module test_epaper_cmd_decoder_1c_38;
   logic       mclk = 1'b0, rst = 1'b1, bs1 = 1'b0, prev_busy = 1'b0;
   logic [7:0] lvl = 8'h5a, r, cfg, p1, p2, ram_opt, cel;
   logic [7:0] pc [2] = '{8'h80, 8'hc0};
   logic [1:0] pf [2] = '{2'b10, 2'b11};
   logic [1:0] abf;
   wire  logic scl, sdi, cs_n, dc, sdo, oe, busy, cef, aef;
   int         fail_count = 0, comparisons = 0, run_len = 0, k;
   always #5 mclk = ~mclk;
   always @(negedge mclk) begin
      if (busy === 1'b1) run_len <= (prev_busy === 1'b1) ? run_len + 1 : 1;
      prev_busy <= busy;
   end
   epcd_cmd_decoder #(.SEC_CYCLES(32'h0000_0014)) dut (.mclk(mclk), .rst(rst), .scl(scl), .sdi(sdi),
      .cs_n(cs_n), .dc(dc), .bs1(bs1), .sensed_level(lvl), .sdo(sdo), .sdo_oe(oe), .busy(busy),
      .clock_enable_flag(cef), .analog_enable_flag(aef), .sensor_start(), .sensor_cfg(cfg),
      .sensor_param1(p1), .sensor_param2(p2), .ram_option(ram_opt), .stage_temp_load(),
      .stage_lut_load(), .stage_display(), .display_mode2(), .alternating_buffer_flag(abf),
      .common_electrode_level(cel));
   epcd_host_model host (.mclk(mclk), .sdo(sdo), .sdo_oe(oe), .scl(scl), .sdi(sdi), .cs_n(cs_n),
      .dc(dc));
   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      comparisons++;
      if (seen !== exp) begin
         fail_count++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic test_done;
      if (fail_count == 0 && comparisons > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   task automatic cmd(input logic [7:0] c);
      host.xfer(bs1, 1'b0, c, r);
   endtask
   task automatic dat(input logic [7:0] d);
      host.xfer(bs1, 1'b1, d, r);
   endtask
   task automatic idle;
      for (k = 0; k < 3000 && busy !== 1'b0; k++) @(negedge mclk);
      if (k == 3000) begin
         fail_count++;
         test_done();
      end
   endtask
   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      repeat (10) @(negedge mclk);
      rst = 1'b0;
      repeat (5) @(negedge mclk);
      chk({busy, cef, aef, ram_opt}, 16'h0000);
      chk({cfg, p1}, 16'h0000);
      for (int i = 0; i < 2; i++) begin
         cmd(8'h22);
         dat(pc[i]);
         cmd(8'h20);
         idle();
         chk(16'(run_len), 16'h0040);
         chk({cef, aef}, pf[i]);
      end
      cmd(8'h29);
      dat(8'h42);
      cmd(8'h28);
      idle();
      // Sense length is (nibble + 1) seconds of 20 cycles each
      chk(16'(run_len), 16'h003c);
      chk(cel, 8'h5a);
      cmd(8'h35);
      dat(8'h00);
      chk(r, 8'hff);
      dat(8'h00);
      chk(r, 8'hff);
      dat(8'h00);
      chk(r, 8'h00);
      cmd(8'h34);
      idle();
      chk(16'(run_len), 16'h0015);
      cmd(8'h1c);
      dat(8'h40);
      dat(8'h5a);
      dat(8'h77);
      dat(8'h99);
      idle();
      chk({cfg, p1}, 16'h405a);
      chk(p2, 8'h77);
      chk(16'(run_len), 16'h0040);
      for (k = 0; k < 10; k++) dat((k == 5) ? 8'hc0 : 8'h00);
      cmd(8'h37);
      for (k = 0; k < 10; k++) dat((k == 5) ? 8'h80 : 8'h00);
      chk(abf, 2'b10);
      cmd(8'h24);
      dat(8'ha5);
      cmd(8'h26);
      dat(8'h3c);
      cmd(8'h27);
      dat(8'h00);
      chk(r, 8'h00);
      dat(8'h00);
      chk(r, 8'ha5);
      cmd(8'h41);
      dat(8'h01);
      cmd(8'h27);
      dat(8'h00);
      dat(8'h00);
      chk(r, 8'h3c);
      cmd(8'h21);
      dat(8'h08);
      dat(8'hff);
      chk(ram_opt, 8'h08);
      cmd(8'h41);
      dat(8'h00);
      cmd(8'h27);
      dat(8'h00);
      dat(8'h00);
      chk(r, 8'h5a);
      bs1 = 1'b1;
      cmd(8'h24);
      dat(8'h96);
      cmd(8'h27);
      dat(8'h00);
      dat(8'h00);
      chk(r, 8'h69);
      cmd(8'h22);
      dat(8'h03);
      dat(8'h80);
      cmd(8'h20);
      idle();
      chk({cef, aef}, 2'b00);
      cmd(8'h28);
      chk(busy, 1'b0);
      cmd(8'h2a);
      chk(busy, 1'b0);
      test_done();
   end
endmodule // test_epaper_cmd_decoder_1c_38
`default_nettype wire
